// ### rtl/etm_params.svh
// Purpose: constants for the event trigger measure/hold block
// Assumes: 32-bit AHB-Lite register words, byte addresses
// Notes: offsets are byte addresses of aligned words
`ifndef ETM_PARAMS_SVH
`define ETM_PARAMS_SVH
`define ETM_OFS_CTRL     8'h00
`define ETM_OFS_STARTUP  8'h04
`define ETM_OFS_ALARM    8'h08
`define ETM_OFS_STATUS   8'h0C
`define ETM_OFS_READING  8'h10
`define ETM_OFS_MAX      8'h14
`define ETM_OFS_MIN      8'h18
`define ETM_OFS_TARE     8'h1C
`define ETM_MODE_LAST    3'h4
`define ETM_STARTUP_RST  16'h0000
`define ETM_IN_GATE      0
`define ETM_IN_STUP      1
`define ETM_IN_FRZ       2
`define ETM_IN_CLR       3
`define ETM_IN_TARE      4
`define ETM_ST_VALID     0
`define ETM_ST_DATA      1
`define ETM_ST_STARTUP   2
`define ETM_ST_GATE      3
`define ETM_ST_FREEZE    4
`define ETM_ST_RUN       5
`define ETM_ST_TARE      6
`define ETM_ST_ALARM     7
`endif

// ### rtl/etm_pkg.sv
// Purpose: shared types for the event trigger measure/hold block
// Assumes: mode codes follow declaration order, 0 to 4
// Notes: codes 5..7 are refused on write
package etm_pkg;
   typedef enum logic [2:0] {
      continuous_mode,
      sample_latch_mode,
      max_capture_mode,
      min_capture_mode,
      span_capture_mode
   } etm_mode_t;
endpackage

// ### rtl/etm_core.sv
// Purpose: gate, hold, capture and reset of meter samples from contact inputs
// Assumes: sample_data, sample_valid, scale_err come from logic on hclk
// Notes: one wait state on every AHB-Lite transfer, response always OKAY
//
// Our own choices: the AHB-Lite register port and the register offsets.
`include "etm_params.svh"
module etm_core #(
   parameter int DW = 20
) (
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic               hreadyout,
   output logic               hresp,
   output logic [31:0]        hrdata,
   input  wire logic          gate_n,
   input  wire logic          startup_delay_in_n,
   input  wire logic          freeze_n,
   input  wire logic          clear_n,
   input  wire logic          tare_n,
   input  wire logic          sample_valid,
   input  wire logic [DW-1:0] sample_data,
   input  wire logic          scale_err,
   output logic [DW:0]        reading,
   output logic               data_valid,
   output logic [DW:0]        dc_out,
   output logic               gate_indicator,
   output logic               err_display,
   output logic               alarm_out
);
   localparam int RW = DW + 1;

   // refused widths: status word and sign extension assume 8..31
   if (DW < 8 || DW > 31) begin
      $error("etm_core: DW must lie in 8..31");
   end

   typedef struct packed {
      logic [4:0]          s1;
      logic [4:0]          s2;
      logic [4:0]          act;
      logic                g_prev;
      logic                frz_prev;
      etm_pkg::etm_mode_t  mode;
      logic [15:0]         st_period;
      logic [15:0]         cnt;
      logic [RW-1:0]       alarm_lvl;
      logic [RW-1:0]       meas;
      logic [RW-1:0]       frz_val;
      logic [RW-1:0]       reading;
      logic [RW-1:0]       dc;
      logic [RW-1:0]       maxv;
      logic [RW-1:0]       minv;
      logic [RW-1:0]       tare_ofs;
      logic [DW-1:0]       raw_last;
      logic                have_data;
      logic                run_valid;
      logic                rd_valid;
      logic                frz_gate;
      logic                tare_on;
      logic                alarm;
      logic                gate_ind;
      logic                err_disp;
      logic                a_sel;
      logic                a_wr;
      logic [7:0]          a_addr;
      logic [31:0]         rdata;
      logic                rdy;
      logic                resp;
   } etm_st_t;

   etm_st_t st;
   etm_st_t nx;

   logic          clr;
   logic          frz;
   logic          cont;
   logic          frz_on;
   logic          g_eff;
   logic          g_on;
   logic          g_off;
   logic          ign;
   logic          stup;
   logic          tare_req;
   logic          run;
   logic          en;
   logic          cap;
   logic          rv;
   logic          trk_en;
   logic [RW-1:0] trk_val;
   logic [RW-1:0] smp;

   function automatic logic [31:0] sx(input logic [RW-1:0] v);
      sx = {{(32 - RW){v[RW-1]}}, v};
   endfunction

   assign clr    = st.s2[`ETM_IN_CLR];
   assign frz    = st.s2[`ETM_IN_FRZ] & ~clr;
   assign cont   = (st.mode == etm_pkg::continuous_mode);
   assign cap    = ~cont & (st.mode != etm_pkg::sample_latch_mode);
   assign frz_on = frz & ~st.frz_prev;
   // frozen gate only once latched; on the freeze edge the live level equals it
   assign g_eff  = (frz & ~cont & st.frz_prev) ? st.frz_gate : st.s2[`ETM_IN_GATE];
   assign g_on   = g_eff & ~st.g_prev;
   assign g_off  = ~g_eff & st.g_prev;
   assign ign    = cont & frz;
   assign stup   = st.s2[`ETM_IN_STUP] & ~st.act[`ETM_IN_STUP] & ~ign;
   // tare refused while frozen, without data or in scale error; no lockout gates it
   assign tare_req = st.s2[`ETM_IN_TARE] & ~st.act[`ETM_IN_TARE] & ~frz
                   & st.have_data & ~scale_err & ~clr;
   assign run    = (st.cnt == 16'h0000) & ~clr;
   assign en     = sample_valid & run & ~frz & (cont | ~scale_err);
   assign smp    = {sample_data[DW-1], sample_data} - (st.tare_on ? st.tare_ofs : '0);
   assign rv     = st.run_valid & ~(cap & g_on & ~frz);
   // sample latch updates max/min with the captured value at the gate edge
   assign trk_en  = cont ? en
                  : (cap ? (g_eff & en)
                         : (g_on & st.have_data & run & ~frz));
   assign trk_val = cont | cap ? smp : st.meas;

   always_comb begin
      nx = st;
      // two stages before any edge logic, asserted-high inside
      nx.s1       = ~{tare_n, clear_n, freeze_n, startup_delay_in_n, gate_n};
      nx.s2       = st.s1;
      nx.act      = st.s2;
      nx.g_prev   = g_eff;
      nx.frz_prev = frz;
      nx.gate_ind = st.s2[`ETM_IN_GATE];
      nx.err_disp = cont & scale_err;
      if (frz_on) begin
         nx.frz_val  = st.meas;
         nx.frz_gate = st.s2[`ETM_IN_GATE];
      end
      if (stup) begin
         nx.cnt = st.st_period;
      end else if (st.cnt != 16'h0000) begin
         nx.cnt = st.cnt - 16'h0001;
      end
      if (en) begin
         nx.raw_last  = sample_data;
         nx.meas      = smp;
         nx.have_data = 1'b1;
      end
      if (trk_en) begin
         nx.run_valid = 1'b1;
         if (!rv || $signed(trk_val) > $signed(st.maxv)) begin
            nx.maxv = trk_val;
         end
         if (!rv || $signed(trk_val) < $signed(st.minv)) begin
            nx.minv = trk_val;
         end
      end else if (cap & g_on & ~frz) begin
         nx.run_valid = 1'b0;
      end
      unique case (st.mode)
         etm_pkg::continuous_mode: begin
            if (en) begin
               nx.reading  = smp;
               nx.rd_valid = 1'b1;
            end
         end
         etm_pkg::sample_latch_mode: begin
            if (g_on & st.have_data & run & ~frz) begin
               nx.reading  = st.meas;
               nx.rd_valid = 1'b1;
            end
         end
         etm_pkg::max_capture_mode: begin
            if (g_off & st.run_valid & ~frz) begin
               nx.reading  = st.maxv;
               nx.rd_valid = 1'b1;
            end
         end
         etm_pkg::min_capture_mode: begin
            if (g_off & st.run_valid & ~frz) begin
               nx.reading  = st.minv;
               nx.rd_valid = 1'b1;
            end
         end
         etm_pkg::span_capture_mode: begin
            if (g_off & st.run_valid & ~frz) begin
               // span wraps if it exceeds RW bits
               nx.reading  = st.maxv - st.minv;
               nx.rd_valid = 1'b1;
            end
         end
         default: begin
         end
      endcase
      if (ign) begin
         nx.reading = frz_on ? st.meas : st.frz_val;
      end
      if (tare_req) begin
         nx.tare_on  = ~st.tare_on;
         nx.tare_ofs = {st.raw_last[DW-1], st.raw_last};
      end
      if (nx.rd_valid && $signed(nx.reading) > $signed(st.alarm_lvl)) begin
         nx.alarm = 1'b1;
      end
      if (clr) begin
         nx.have_data = 1'b0;
         nx.rd_valid  = 1'b0;
         nx.run_valid = 1'b0;
         nx.maxv      = '0;
         nx.minv      = '0;
         nx.alarm     = 1'b0;
      end
      nx.dc = nx.rd_valid ? nx.reading : '0;
      // registered data phase: one wait state keeps hrdata a flop output
      if (st.a_sel) begin
         nx.a_sel = 1'b0;
         nx.rdy   = 1'b1;
         nx.rdata = 32'h0000_0000;
         if (st.a_wr) begin
            unique case (st.a_addr)
               `ETM_OFS_CTRL: begin
                  if (hwdata[2:0] <= `ETM_MODE_LAST) begin
                     nx.mode = etm_pkg::etm_mode_t'(hwdata[2:0]);
                  end
               end
               `ETM_OFS_STARTUP: nx.st_period = hwdata[15:0];
               `ETM_OFS_ALARM:   nx.alarm_lvl = hwdata[RW-1:0];
               default: begin
               end
            endcase
         end else begin
            unique case (st.a_addr)
               `ETM_OFS_CTRL:    nx.rdata = {29'h0000_0000, st.mode};
               `ETM_OFS_STARTUP: nx.rdata = {16'h0000, st.st_period};
               `ETM_OFS_ALARM:   nx.rdata = sx(st.alarm_lvl);
               `ETM_OFS_STATUS: begin
                  nx.rdata[`ETM_ST_VALID]   = st.rd_valid;
                  nx.rdata[`ETM_ST_DATA]    = st.have_data;
                  nx.rdata[`ETM_ST_STARTUP] = (st.cnt != 16'h0000);
                  nx.rdata[`ETM_ST_GATE]    = g_eff;
                  nx.rdata[`ETM_ST_FREEZE]  = frz;
                  nx.rdata[`ETM_ST_RUN]     = st.run_valid;
                  nx.rdata[`ETM_ST_TARE]    = st.tare_on;
                  nx.rdata[`ETM_ST_ALARM]   = st.alarm;
               end
               `ETM_OFS_READING: nx.rdata = sx(st.reading);
               `ETM_OFS_MAX:     nx.rdata = sx(st.maxv);
               `ETM_OFS_MIN:     nx.rdata = sx(st.minv);
               `ETM_OFS_TARE:    nx.rdata = sx(st.tare_ofs);
               default: begin
               end
            endcase
         end
      end
      if (hsel && htrans[1] && hready) begin
         nx.a_sel  = 1'b1;
         nx.a_wr   = hwrite;
         nx.a_addr = {haddr[7:2], 2'b00};
         nx.rdy    = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st      <= '0;
         st.mode <= etm_pkg::continuous_mode;
         st.cnt  <= `ETM_STARTUP_RST;
         st.st_period <= `ETM_STARTUP_RST;
         st.rdy  <= 1'b1;
      end else begin
         st <= nx;
      end
   end

   assign hreadyout      = st.rdy;
   assign hresp          = st.resp;
   assign hrdata         = st.rdata;
   assign reading        = st.reading;
   assign data_valid     = st.rd_valid;
   assign dc_out         = st.dc;
   assign gate_indicator = st.gate_ind;
   assign err_display    = st.err_disp;
   assign alarm_out      = st.alarm;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   property p_gate_ind;
      (!gate_n) [*4] |=> gate_indicator;
   endproperty
   a_gate_ind: assert property (p_gate_ind) else $error("gate indicator not lit");

   property p_mode_legal;
      st.mode <= `ETM_MODE_LAST;
   endproperty
   a_mode_legal: assert property (p_mode_legal) else $error("illegal mode held");

   property p_cont_track;
      (cont && en) |=> (reading == $past(smp)) && data_valid;
   endproperty
   a_cont_track: assert property (p_cont_track) else $error("continuous sample lost");

   property p_startup_block;
      // a freeze edge during startup in continuous mode still loads the last measured value into reading
      (st.cnt != 16'h0000 && !frz_on) |=> $stable(reading);
   endproperty
   a_startup_block: assert property (p_startup_block) else $error("measured in startup");

   property p_freeze_hold;
      frz |=> $stable(st.maxv) && $stable(st.minv);
   endproperty
   a_freeze_hold: assert property (p_freeze_hold) else $error("max/min moved in freeze");

   property p_cont_freeze;
      (cont && frz && st.frz_prev) |=> reading == $past(st.frz_val);
   endproperty
   a_cont_freeze: assert property (p_cont_freeze) else $error("frozen value not shown");

   property p_max_final;
      (st.mode == etm_pkg::max_capture_mode && g_off && st.run_valid && !frz && !clr)
         |=> data_valid && reading == $past(st.maxv);
   endproperty
   a_max_final: assert property (p_max_final) else $error("peak not presented");

   property p_span_final;
      (st.mode == etm_pkg::span_capture_mode && g_off && st.run_valid && !frz && !clr)
         |=> reading == $past(st.maxv - st.minv);
   endproperty
   a_span_final: assert property (p_span_final) else $error("span not presented");

   property p_clear;
      clr |=> !data_valid && !alarm_out && st.maxv == '0 && !st.run_valid;
   endproperty
   a_clear: assert property (p_clear) else $error("clear input not honoured");

   property p_dc_zero;
      !data_valid |-> dc_out == '0;
   endproperty
   a_dc_zero: assert property (p_dc_zero) else $error("dc output without data");

   property p_bus_ans;
      (hsel && htrans[1] && hready) |=> !hreadyout ##1 hreadyout;
   endproperty
   a_bus_ans: assert property (p_bus_ans) else $error("bus answer timing off");

   property p_latch_take;
      (st.mode == etm_pkg::sample_latch_mode && g_on && st.have_data && run && !frz && !clr)
         |=> data_valid && reading == $past(st.meas);
   endproperty
   a_latch_take: assert property (p_latch_take) else $error("sample not latched");

   property p_min_final;
      (st.mode == etm_pkg::min_capture_mode && g_off && st.run_valid && !frz && !clr)
         |=> data_valid && reading == $past(st.minv);
   endproperty
   a_min_final: assert property (p_min_final) else $error("valley not presented");

   property p_err_meas;
      (cont && scale_err && en) |=> err_display && data_valid && reading == $past(smp);
   endproperty
   a_err_meas: assert property (p_err_meas) else $error("measuring stopped in error");

   property p_clr_hold;
      (clr && cont) |=> $stable(reading) && !data_valid;
   endproperty
   a_clr_hold: assert property (p_clr_hold) else $error("measured under clear");

   property p_tare_toggle;
      tare_req |=> st.tare_on != $past(st.tare_on);
   endproperty
   a_tare_toggle: assert property (p_tare_toggle) else $error("tare request lost");

   c_peak: cover property (st.mode == etm_pkg::max_capture_mode && g_off && st.run_valid);
   c_latch: cover property (st.mode == etm_pkg::sample_latch_mode && g_on && st.have_data);
   c_freeze: cover property (cont && frz_on);
   c_tare: cover property (tare_req);
endmodule

// ### testbench/etm_contact_model.sv
// Purpose: contact lines and sample source beside the measure/hold block
// Assumes: driven from hclk rising edges, non-blocking
// Notes: released contacts float high, as a pulled-up contact does
`include "etm_params.svh"
module etm_contact_model #(
   parameter int DW = 20
) (
   input  wire logic    hclk,
   output logic         gate_n,
   output logic         startup_delay_in_n,
   output logic         freeze_n,
   output logic         clear_n,
   output logic         tare_n,
   output logic         sample_valid,
   output logic [DW-1:0] sample_data,
   output logic         scale_err
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] pins_n_ff = 5'h1F;
   assign gate_n             = pins_n_ff[`ETM_IN_GATE];
   assign startup_delay_in_n = pins_n_ff[`ETM_IN_STUP];
   assign freeze_n           = pins_n_ff[`ETM_IN_FRZ];
   assign clear_n            = pins_n_ff[`ETM_IN_CLR];
   assign tare_n             = pins_n_ff[`ETM_IN_TARE];
   initial begin
      sample_valid = 1'b0;
      sample_data  = '0;
      scale_err    = 1'b0;
   end
   // held well past the 3-edge sync so every edge is seen
   task automatic press(input int idx, input logic on);
      @(posedge hclk);
      pins_n_ff[idx] <= !on;
      repeat (6) @(posedge hclk);
   endtask
   // scaling error level, moved just after an edge like the samples
   task automatic fault(input logic on);
      @(posedge hclk);
      scale_err <= on;
   endtask
   // data line scrambled once the sample is gone
   task automatic feed(input logic [DW-1:0] v);
      @(posedge hclk);
      sample_valid <= 1'b1;
      sample_data  <= v;
      @(posedge hclk);
      sample_valid <= 1'b0;
      sample_data  <= ~v;
      repeat (4) @(posedge hclk);
   endtask
endmodule

// ### testbench/etm_core_test.sv
// Purpose: register and contact sequences against the measure/hold block
// Assumes: one wait state per bus transfer, contacts 3 edges to act
// Notes: scale error raised in continuous mode only
`include "etm_params.svh"
module etm_core_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        gate_n, startup_delay_in_n, freeze_n, clear_n, tare_n;
   logic        sample_valid, scale_err, data_valid, gate_indicator;
   logic        err_display, alarm_out;
   logic [19:0] sample_data;
   logic [20:0] reading, dc_out;
   int          num_errors = 0;
   int          n_tests = 0;
   logic [31:0] cap_exp [3] = '{32'h0000_0028, 32'hFFFF_FFFD, 32'h0000_002B};

   etm_core #(.DW(20)) etm_core_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .gate_n(gate_n),
      .startup_delay_in_n(startup_delay_in_n), .freeze_n(freeze_n), .clear_n(clear_n),
      .tare_n(tare_n), .sample_valid(sample_valid), .sample_data(sample_data),
      .scale_err(scale_err), .reading(reading), .data_valid(data_valid),
      .dc_out(dc_out), .gate_indicator(gate_indicator), .err_display(err_display),
      .alarm_out(alarm_out));
   etm_contact_model #(.DW(20)) etm_contact_model_inst (
      .hclk(hclk), .gate_n(gate_n), .startup_delay_in_n(startup_delay_in_n),
      .freeze_n(freeze_n), .clear_n(clear_n), .tare_n(tare_n),
      .sample_valid(sample_valid), .sample_data(sample_data), .scale_err(scale_err));

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   task automatic results();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // address held until hready seen high, data taken at completion edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr  <= {24'h00_0000, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      v = hrdata;
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      chk(what, exp, v);
   endtask

   function automatic logic [31:0] sx(input logic [20:0] x);
      return {{11{x[20]}}, x};
   endfunction

   initial begin
      repeat (20000) @(posedge hclk);
      num_errors++;
      $display("ERROR watchdog expected finish seen hang");
      results();
   end

   initial begin
      hresetn = 1'b0;
      hsel    = 1'b0;
      haddr   = 32'h0000_0000;
      htrans  = 2'b00;
      hwrite  = 1'b0;
      hsize   = 3'h2;
      hwdata  = 32'h0000_0000;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk("ctrl", `ETM_OFS_CTRL, 32'h0000_0000);
      chk("data_valid", 32'h0000_0000, {31'h0, data_valid});
      chk("hresp", 32'h0000_0000, {31'h0, hresp});
      rd_chk("unmapped", 8'h40, 32'h0000_0000);
      etm_contact_model_inst.feed(20'h0_0064);
      chk("dc_out", 32'h0000_0064, sx(dc_out));
      etm_contact_model_inst.press(`ETM_IN_GATE, 1'b1);
      chk("gate_ind", 32'h0000_0001, {31'h0, gate_indicator});
      etm_contact_model_inst.feed(20'h0_0065);
      rd_chk("reading", `ETM_OFS_READING, 32'h0000_0065);
      etm_contact_model_inst.press(`ETM_IN_GATE, 1'b0);
      etm_contact_model_inst.press(`ETM_IN_TARE, 1'b1);
      etm_contact_model_inst.press(`ETM_IN_TARE, 1'b0);
      xfer(1'b0, `ETM_OFS_STATUS, 32'h0000_0000);
      chk("tare_on", 32'h0000_0001, {31'h0, v[`ETM_ST_TARE]});
      etm_contact_model_inst.press(`ETM_IN_TARE, 1'b1);
      etm_contact_model_inst.press(`ETM_IN_TARE, 1'b0);
      etm_contact_model_inst.feed(20'h0_00C8);
      etm_contact_model_inst.press(`ETM_IN_FRZ, 1'b1);
      rd_chk("frozen", `ETM_OFS_READING, 32'h0000_00C8);
      etm_contact_model_inst.feed(20'h0_012C);
      etm_contact_model_inst.press(`ETM_IN_TARE, 1'b1);
      etm_contact_model_inst.press(`ETM_IN_TARE, 1'b0);
      rd_chk("frozen", `ETM_OFS_READING, 32'h0000_00C8);
      xfer(1'b0, `ETM_OFS_STATUS, 32'h0000_0000);
      chk("tare_frz", 32'h0000_0000, {31'h0, v[`ETM_ST_TARE]});
      etm_contact_model_inst.press(`ETM_IN_FRZ, 1'b0);
      chk("alarm_out", 32'h0000_0001, {31'h0, alarm_out});
      etm_contact_model_inst.press(`ETM_IN_CLR, 1'b1);
      chk("data_valid", 32'h0000_0000, {31'h0, data_valid});
      chk("dc_out", 32'h0000_0000, sx(dc_out));
      rd_chk("max", `ETM_OFS_MAX, 32'h0000_0000);
      chk("alarm_out", 32'h0000_0000, {31'h0, alarm_out});
      etm_contact_model_inst.press(`ETM_IN_CLR, 1'b0);
      // out-of-range mode must leave continuous in place
      xfer(1'b1, `ETM_OFS_CTRL, 32'h0000_0005);
      rd_chk("ctrl", `ETM_OFS_CTRL, 32'h0000_0000);
      xfer(1'b1, `ETM_OFS_CTRL, 32'h0000_0001);
      etm_contact_model_inst.feed(20'h0_0032);
      etm_contact_model_inst.press(`ETM_IN_GATE, 1'b1);
      etm_contact_model_inst.feed(20'h0_0046);
      rd_chk("latched", `ETM_OFS_READING, 32'h0000_0032);
      etm_contact_model_inst.press(`ETM_IN_GATE, 1'b0);
      for (int k = 0; k < 3; k++) begin
         xfer(1'b1, `ETM_OFS_CTRL, 32'(k + 2));
         etm_contact_model_inst.press(`ETM_IN_GATE, 1'b1);
         etm_contact_model_inst.feed(20'h0_0005);
         etm_contact_model_inst.feed(20'h0_0028);
         etm_contact_model_inst.feed(20'hF_FFFD);
         etm_contact_model_inst.press(`ETM_IN_GATE, 1'b0);
         rd_chk("capture", `ETM_OFS_READING, cap_exp[k]);
      end
      xfer(1'b1, `ETM_OFS_CTRL, 32'h0000_0000);
      xfer(1'b1, `ETM_OFS_STARTUP, 32'h0000_0020);
      etm_contact_model_inst.feed(20'h0_0010);
      etm_contact_model_inst.press(`ETM_IN_STUP, 1'b1);
      etm_contact_model_inst.press(`ETM_IN_STUP, 1'b0);
      etm_contact_model_inst.feed(20'h0_0077);
      rd_chk("startup", `ETM_OFS_READING, 32'h0000_0010);
      repeat (40) @(posedge hclk);
      etm_contact_model_inst.feed(20'h0_0078);
      rd_chk("startup", `ETM_OFS_READING, 32'h0000_0078);
      etm_contact_model_inst.fault(1'b1);
      etm_contact_model_inst.feed(20'h0_0090);
      chk("err_display", 32'h0000_0001, {31'h0, err_display});
      rd_chk("err_meas", `ETM_OFS_READING, 32'h0000_0090);
      etm_contact_model_inst.press(`ETM_IN_FRZ, 1'b1);
      etm_contact_model_inst.fault(1'b0);
      etm_contact_model_inst.feed(20'h0_00A0);
      chk("err_display", 32'h0000_0000, {31'h0, err_display});
      rd_chk("err_frz", `ETM_OFS_READING, 32'h0000_0090);
      etm_contact_model_inst.press(`ETM_IN_FRZ, 1'b0);
      xfer(1'b1, `ETM_OFS_CTRL, 32'h0000_0004);
      rd_chk("ctrl_span", `ETM_OFS_CTRL, 32'h0000_0004);
      // second reset in mid-run must bring continuous mode back
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk("ctrl_rst", `ETM_OFS_CTRL, 32'h0000_0000);
      chk("dc_rst", 32'h0000_0000, sx(dc_out));
      results();
   end
endmodule
